// file: rtl/pwe_top.v
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pwe_defs.vh"

// Overview of operation
// - Matching magic packet sets wake flag bit 2
// - Link-up sets bit 1, write one clears
// - Cable energy sets bit 0, write one clears
// - Link and energy bits only on PHY ports
// - Enable bit 2 gates magic packet wake
// - Enable bit 1 gates link-up wake
// - Enable bit 0 gates energy wake
// - Status bit 2 summarises timestamp interrupts
// - Status bit 1 summarises PHY interrupts
// - Counter-mode ACL interrupt sets status bit 0
// - ACL bit clears only on mask toggle
// - Status forwarded only when mask enables it
// - Mask zero enables, one disables
module pwe_top #(
	parameter NUM_PORTS = 3,
	parameter [2:0] PHY_PORT_MASK = 3'h3
) (
	input wire sys_clk,
	input wire rst,
	input wire [`PWE_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [`PWE_DATA_W-1:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`PWE_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [`PWE_DATA_W-1:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [47:0] switch_mac_addr,
	input wire [47:0] magic_dest_addr,
	input wire [NUM_PORTS-1:0] magic_packet_seen,
	input wire [NUM_PORTS-1:0] link_up_seen,
	input wire [NUM_PORTS-1:0] energy_seen,
	input wire [NUM_PORTS-1:0] ts_irq_pending,
	input wire [NUM_PORTS-1:0] phy_irq_pending,
	input wire [NUM_PORTS-1:0] acl_irq,
	output reg power_event_output,
	output reg [NUM_PORTS-1:0] port_irq,
	output wire irq
);

	// ==================================================
	// Write channel capture
	reg aw_held;
	reg w_held;
	reg [`PWE_ADDR_W-1:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane0;
	wire wr_fire;
	wire [`PWE_IDX_W-1:0] wr_idx;
	wire [1:0] wr_port;
	wire [11:0] wr_reg;
	wire wr_map;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign wr_idx = aw_addr[`PWE_ADDR_W-1:`PWE_IDX_LSB];
	assign wr_port = wr_idx[`PWE_PORT_HI:`PWE_PORT_LO];
	assign wr_reg = wr_idx[`PWE_REG_HI:0];

	always @(posedge sys_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {`PWE_ADDR_W{1'b0}};
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PWE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `PWE_RESP_OKAY : `PWE_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==================================================
	// Read channel decode
	wire rd_fire;
	wire [`PWE_IDX_W-1:0] rd_idx;
	wire [1:0] rd_port;
	wire [11:0] rd_reg;

	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign rd_idx = s_axi_araddr[`PWE_ADDR_W-1:`PWE_IDX_LSB];
	assign rd_port = rd_idx[`PWE_PORT_HI:`PWE_PORT_LO];
	assign rd_reg = rd_idx[`PWE_REG_HI:0];

	// ==================================================
	// Register decode
	wire wr_is_flags;
	wire wr_is_en;
	wire wr_is_mask;
	wire wr_is_irq_status;
	wire wr_is_irq_mask;
	wire rd_is_flags;
	wire rd_is_irq_status;
	wire rd_is_irq_mask;

	assign wr_is_flags = (wr_reg == `PWE_REG_WAKE_FLAGS);
	assign wr_is_en = (wr_reg == `PWE_REG_WAKE_EN);
	assign wr_is_mask = (wr_reg == `PWE_REG_INT_MASK);
	assign wr_is_irq_status = (wr_idx == `PWE_IDX_IRQ_STATUS);
	assign wr_is_irq_mask = (wr_idx == `PWE_IDX_IRQ_MASK);
	assign rd_is_flags = (rd_reg == `PWE_REG_WAKE_FLAGS);
	assign rd_is_irq_status = (rd_idx == `PWE_IDX_IRQ_STATUS);
	assign rd_is_irq_mask = (rd_idx == `PWE_IDX_IRQ_MASK);

	// ==================================================
	// Per-port register copies
	wire magic_match;
	wire [3*NUM_PORTS-1:0] wake_flags;
	wire [3*NUM_PORTS-1:0] wake_en;
	wire [3*NUM_PORTS-1:0] int_status;
	wire [3*NUM_PORTS-1:0] int_mask;
	wire [NUM_PORTS-1:0] port_wake;
	wire [NUM_PORTS-1:0] port_fwd;
	wire [NUM_PORTS-1:0] wake_set_ev;
	wire [NUM_PORTS-1:0] port_wr_ok;
	wire [NUM_PORTS-1:0] port_rd_ok;
	wire [8*NUM_PORTS-1:0] port_rd;

	assign magic_match = (magic_dest_addr == switch_mac_addr);

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
			localparam integer PNUM_I = p + 1;
			localparam [1:0] PNUM = PNUM_I[1:0];
			localparam IS_PHY = PHY_PORT_MASK[p];
			reg [2:0] flags;
			reg [2:0] en;
			reg acl_flag;
			reg [2:0] mask;
			wire [2:0] status;
			wire wr_here;
			wire rd_here;
			wire set_magic;
			wire set_link;
			wire set_energy;
			wire clr_magic;
			wire clr_link;
			wire clr_energy;
			wire acl_clr;

			assign wr_here = wr_fire & w_lane0 & (wr_port == PNUM);
			assign rd_here = rd_fire & (rd_port == PNUM);
			assign set_magic = magic_packet_seen[p] & magic_match;
			assign set_link = link_up_seen[p] & IS_PHY;
			assign set_energy = energy_seen[p] & IS_PHY;
			assign clr_magic = rd_here & rd_is_flags;
			assign clr_link = wr_here & wr_is_flags & w_byte[`PWE_BIT_LINK];
			assign clr_energy = wr_here & wr_is_flags & w_byte[`PWE_BIT_ENERGY];
			assign acl_clr = wr_here & wr_is_mask & (w_byte[`PWE_BIT_ACL] != mask[`PWE_BIT_ACL]);

			always @(posedge sys_clk) begin
				if (rst) begin
					flags <= `PWE_RST_FIELD3;
					en <= `PWE_RST_FIELD3;
					acl_flag <= 1'b0;
					mask <= `PWE_RST_INT_MASK;
				end else begin
					flags[`PWE_BIT_MAGIC] <= set_magic | (flags[`PWE_BIT_MAGIC] & ~clr_magic);
					flags[`PWE_BIT_LINK] <= set_link | (flags[`PWE_BIT_LINK] & ~clr_link);
					flags[`PWE_BIT_ENERGY] <= set_energy | (flags[`PWE_BIT_ENERGY] & ~clr_energy);
					if (wr_here && wr_is_en) begin
						en <= w_byte[2:0] & {1'b1, IS_PHY[0], IS_PHY[0]};
					end
					acl_flag <= acl_irq[p] | (acl_flag & ~acl_clr);
					if (wr_here && wr_is_mask) begin
						mask <= w_byte[2:0];
					end
				end
			end

			assign status[`PWE_BIT_TS] = ts_irq_pending[p] & IS_PHY;
			assign status[`PWE_BIT_PHY] = phy_irq_pending[p] & IS_PHY;
			assign status[`PWE_BIT_ACL] = acl_flag;
			assign wake_flags[3*p+:3] = flags;
			assign wake_en[3*p+:3] = en;
			assign int_status[3*p+:3] = status;
			assign int_mask[3*p+:3] = mask;
			assign port_wake[p] = |(flags & en);
			assign port_fwd[p] = |(status & ~mask);
			assign wake_set_ev[p] = set_magic | set_link | set_energy;
			assign port_wr_ok[p] = (wr_port == PNUM) &&
				((wr_reg == `PWE_REG_WAKE_FLAGS) || (wr_reg == `PWE_REG_WAKE_EN) ||
				(wr_reg == `PWE_REG_INT_STATUS) || (wr_reg == `PWE_REG_INT_MASK));
			assign port_rd_ok[p] = (rd_port == PNUM) &&
				((rd_reg == `PWE_REG_WAKE_FLAGS) || (rd_reg == `PWE_REG_WAKE_EN) ||
				(rd_reg == `PWE_REG_INT_STATUS) || (rd_reg == `PWE_REG_INT_MASK));
			assign port_rd[8*p+:8] = (rd_reg == `PWE_REG_WAKE_FLAGS) ? {5'h00, flags} :
				(rd_reg == `PWE_REG_WAKE_EN) ? {5'h00, en} :
				(rd_reg == `PWE_REG_INT_STATUS) ? {5'h00, status} :
				{5'h00, mask};
		end
	endgenerate

	// ==================================================
	// Block interrupt status and mask
	reg [5:0] irq_status;
	reg [5:0] irq_mask;
	wire [5:0] irq_ev;
	wire [5:0] irq_clr;
	wire glb_wr;

	assign glb_wr = wr_fire & w_lane0;
	assign irq_ev = {acl_irq, wake_set_ev};
	assign irq_clr = (glb_wr && wr_is_irq_status) ? s_axi_wdata_clr(w_byte) : 6'h00;
	assign irq = |(irq_status & ~irq_mask);
	assign wr_map = wr_is_irq_status || wr_is_irq_mask || (|port_wr_ok);

	function [5:0] s_axi_wdata_clr;
		input [7:0] b;
		begin
			s_axi_wdata_clr = b[5:0];
		end
	endfunction

	always @(posedge sys_clk) begin
		if (rst) begin
			irq_status <= `PWE_RST_IRQ_STATUS;
			irq_mask <= `PWE_RST_IRQ_MASK;
		end else begin
			irq_status <= irq_ev | (irq_status & ~irq_clr);
			if (glb_wr && wr_is_irq_mask) begin
				irq_mask <= w_byte[5:0];
			end
		end
	end

	// ==================================================
	// Read data select
	reg [`PWE_DATA_W-1:0] next_rdata;
	reg [1:0] next_rresp;

	always @* begin
		next_rdata = {`PWE_DATA_W{1'b0}};
		next_rresp = `PWE_RESP_OKAY;
		if (rd_is_irq_status) begin
			next_rdata = {26'h0000000, irq_status};
		end else if (rd_is_irq_mask) begin
			next_rdata = {26'h0000000, irq_mask};
		end else if (port_rd_ok[0]) begin
			next_rdata = {24'h000000, port_rd[7:0]};
		end else if (port_rd_ok[1]) begin
			next_rdata = {24'h000000, port_rd[15:8]};
		end else if (port_rd_ok[2]) begin
			next_rdata = {24'h000000, port_rd[23:16]};
		end else begin
			next_rresp = `PWE_RESP_SLVERR;
		end
	end

	// ==================================================
	// Read data and outputs
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= {`PWE_DATA_W{1'b0}};
			s_axi_rresp <= `PWE_RESP_OKAY;
			power_event_output <= 1'b0;
			port_irq <= {NUM_PORTS{1'b0}};
		end else begin
			power_event_output <= |port_wake;
			port_irq <= port_fwd;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// file: pkg/pwe_defs.vh
`ifndef PWE_DEFS_VH
`define PWE_DEFS_VH

// ==================================================
// Bus geometry
`define PWE_ADDR_W 16
`define PWE_DATA_W 32
`define PWE_IDX_LSB 2
`define PWE_IDX_W 14
`define PWE_PORT_HI 13
`define PWE_PORT_LO 12
`define PWE_REG_HI 11

// ==================================================
// Per-port register indices (byte address is four times index)
`define PWE_REG_WAKE_FLAGS 12'h013
`define PWE_REG_WAKE_EN 12'h017
`define PWE_REG_INT_STATUS 12'h01B
`define PWE_REG_INT_MASK 12'h01F

// ==================================================
// Block interrupt register indices
`define PWE_IDX_IRQ_STATUS 14'h0010
`define PWE_IDX_IRQ_MASK 14'h0011

// ==================================================
// Field positions
`define PWE_BIT_MAGIC 2
`define PWE_BIT_LINK 1
`define PWE_BIT_ENERGY 0
`define PWE_BIT_TS 2
`define PWE_BIT_PHY 1
`define PWE_BIT_ACL 0

// ==================================================
// Reset values and responses
`define PWE_RST_FIELD3 3'h0
`define PWE_RST_INT_MASK 3'h0
`define PWE_RST_IRQ_STATUS 6'h00
`define PWE_RST_IRQ_MASK 6'h3F
`define PWE_RESP_OKAY 2'h0
`define PWE_RESP_SLVERR 2'h2

`endif

// file: verification/pwe_monitor.sv
`timescale 1ns/100ps
// ==========
// Bus and output checks
module pwe_monitor (
	input sys_clk,
	input rst,
	input s_axi_awvalid,
	input s_axi_awready,
	input s_axi_wvalid,
	input s_axi_wready,
	input s_axi_bvalid,
	input s_axi_bready,
	input s_axi_arvalid,
	input s_axi_arready,
	input s_axi_rvalid,
	input s_axi_rready,
	input [2:0] magic_packet_seen,
	input [2:0] link_up_seen,
	input [2:0] energy_seen,
	input [2:0] acl_irq,
	input power_event_output,
	input [2:0] port_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire ev = |{magic_packet_seen, link_up_seen, energy_seen};
	chk_rd_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	chk_wr_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("late write");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
	chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken busy");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken busy");
	chk_wake_cause: assert property ($rose(power_event_output) |->
		$past(ev, 2) || $past(ev, 3) || $past(s_axi_bvalid)) else $error("wake output uncaused");
	chk_acl_cause: assert property ($rose(port_irq[2]) |->
		$past(acl_irq[2], 2) || $past(acl_irq[2], 3) || $past(s_axi_bvalid)) else $error("port irq uncaused");
endmodule
bind pwe_top pwe_monitor u_mon (
	.sys_clk(sys_clk),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.magic_packet_seen(magic_packet_seen),
	.link_up_seen(link_up_seen),
	.energy_seen(energy_seen),
	.acl_irq(acl_irq),
	.power_event_output(power_event_output),
	.port_irq(port_irq)
);

// file: verification/pwe_host.sv
`timescale 1ns/100ps
// ==========
// Host register bus model
module pwe_host (
	input sys_clk,
	output logic [15:0] s_axi_awaddr = 16'h0,
	output logic s_axi_awvalid = 1'h0,
	input s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic s_axi_wvalid = 1'h0,
	input s_axi_wready,
	input [1:0] s_axi_bresp,
	input s_axi_bvalid,
	output logic s_axi_bready = 1'h0,
	output logic [15:0] s_axi_araddr = 16'h0,
	output logic s_axi_arvalid = 1'h0,
	input s_axi_arready,
	input [31:0] s_axi_rdata,
	input [1:0] s_axi_rresp,
	input s_axi_rvalid,
	output logic s_axi_rready = 1'h0
);
	task wr(input [15:0] a, input [31:0] d, output [1:0] r);
		logic pa, pw, ka, kw;
		pa = 1;
		pw = 1;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (pa | pw) begin
			@(negedge sys_clk);
			ka = s_axi_awready & pa;
			kw = s_axi_wready & pw;
			@(posedge sys_clk);
			if (ka) s_axi_awvalid <= 1'h0;
			if (kw) s_axi_wvalid <= 1'h0;
			pa = pa & !ka;
			pw = pw & !kw;
		end
		do @(negedge sys_clk); while (!s_axi_bvalid);
		@(posedge sys_clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input [15:0] a, output [31:0] d, output [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(negedge sys_clk); while (!s_axi_arready);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'h0;
		do @(negedge sys_clk); while (!s_axi_rvalid);
		@(posedge sys_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
endmodule

// file: verification/testbench.sv
`timescale 1ns/100ps
`include "pwe_defs.vh"
module testbench;
	logic sys_clk = 0, rst = 1;
	logic [2:0] magic_packet_seen = 0, link_up_seen = 0, energy_seen = 0, acl_irq = 0;
	logic [2:0] ts_irq_pending = 0, phy_irq_pending = 0;
	logic [47:0] magic_dest_addr = 0;
	wire [47:0] switch_mac_addr = 48'h00000A0B0C0D;
	wire [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, port_irq;
	wire [3:0] s_axi_wstrb = 4'hF;
	wire [15:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, power_event_output, irq;
	int mismatches = 0, check_count = 0, cycles = 0;
	logic [31:0] d;
	logic [1:0] r;
	pwe_top u_dut (.*);
	pwe_host u_host (.*);
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	function [15:0] a(input [1:0] p, input [11:0] g);
		a = {p, g, 2'h0};
	endfunction
	task rc(input [15:0] ad, input [31:0] e);
		u_host.rd(ad, d, r);
		chk("rresp", r, 0);
		chk("rdata", d, e);
	endtask
	task wt(input [15:0] ad, input [31:0] v);
		u_host.wr(ad, v, r);
		chk("bresp", r, 0);
		repeat (2) @(negedge sys_clk);
	endtask
	// Order: magic, link, energy, acl
	task pulse(input [11:0] v);
		@(posedge sys_clk) {magic_packet_seen, link_up_seen, energy_seen, acl_irq} <= v;
		@(posedge sys_clk) {magic_packet_seen, link_up_seen, energy_seen, acl_irq} <= 12'h000;
		repeat (3) @(negedge sys_clk);
	endtask
	// ==========
	// Scenarios
	task t_wake;
		wt(a(1, `PWE_REG_WAKE_EN), 32'h7);
		pulse(12'h008);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h1);
		chk("pme", power_event_output, 1);
		wt(a(1, `PWE_REG_WAKE_FLAGS), 32'h1);
		chk("pme", power_event_output, 0);
		pulse(12'h040);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h2);
		chk("pme", power_event_output, 1);
		wt(a(1, `PWE_REG_WAKE_FLAGS), 32'h2);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h0);
		magic_dest_addr <= switch_mac_addr;
		pulse(12'h200);
		chk("pme", power_event_output, 1);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h4);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h0);
		magic_dest_addr <= ~switch_mac_addr;
		pulse(12'h200);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h0);
		wt(a(1, `PWE_REG_WAKE_EN), 32'h0);
		pulse(12'h048);
		chk("pme", power_event_output, 0);
		wt(a(1, `PWE_REG_WAKE_FLAGS), 32'h3);
	endtask
	task t_port;
		wt(a(3, `PWE_REG_WAKE_EN), 32'h7);
		rc(a(3, `PWE_REG_WAKE_EN), 32'h4);
		pulse(12'h120);
		rc(a(3, `PWE_REG_WAKE_FLAGS), 32'h0);
		pulse(12'h010);
		rc(a(2, `PWE_REG_WAKE_FLAGS), 32'h1);
		rc(a(1, `PWE_REG_WAKE_FLAGS), 32'h0);
	endtask
	task t_int;
		ts_irq_pending <= 3'h5;
		phy_irq_pending <= 3'h5;
		wt(a(1, `PWE_REG_INT_STATUS), 32'h0);
		rc(a(1, `PWE_REG_INT_STATUS), 32'h6);
		rc(a(3, `PWE_REG_INT_STATUS), 32'h0);
		ts_irq_pending <= 3'h0;
		phy_irq_pending <= 3'h0;
		pulse(12'h004);
		rc(a(3, `PWE_REG_INT_STATUS), 32'h1);
		chk("port_irq", port_irq, 3'h4);
		wt(a(3, `PWE_REG_INT_MASK), 32'h6);
		rc(a(3, `PWE_REG_INT_STATUS), 32'h1);
		chk("port_irq", port_irq, 3'h4);
		wt(a(3, `PWE_REG_INT_MASK), 32'h1);
		rc(a(3, `PWE_REG_INT_STATUS), 32'h0);
		pulse(12'h004);
		chk("port_irq", port_irq, 3'h0);
		wt(a(3, `PWE_REG_INT_MASK), 32'h0);
		rc(a(3, `PWE_REG_INT_STATUS), 32'h0);
	endtask
	task t_blk;
		rc(16'h0044, 32'h3F);
		rc(16'h0040, 32'h23);
		chk("irq", irq, 0);
		wt(16'h0044, 32'h0);
		chk("irq", irq, 1);
		wt(16'h0040, 32'h3F);
		chk("irq", irq, 0);
		u_host.rd(16'h0FF0, d, r);
		chk("rresp", r, 2);
		chk("rdata", d, 0);
		u_host.wr(16'h0FF0, 32'h0, r);
		chk("bresp", r, 2);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 0;
		rc(a(2, `PWE_REG_INT_MASK), 32'h0);
		t_wake();
		t_port();
		t_int();
		t_blk();
		stop_test();
	end
endmodule
